// File: logic/dmc_pkg.sv
// Shared constants and types of the drive mode and motion command block
package dmc_pkg;
    localparam int SET_W = 16;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_MODE_PARAM  = 4'h0;
    localparam logic [3:0] ADDR_MODE_ACTIVE = 4'h1;
    localparam logic [3:0] ADDR_TORQUE_SET  = 4'h2;
    localparam logic [3:0] ADDR_TORQUE_RATE = 4'h3;
    localparam logic [3:0] ADDR_SPEED_SET   = 4'h4;
    localparam logic [3:0] ADDR_SPEED_RATE  = 4'h5;
    localparam logic [3:0] ADDR_TARGET      = 4'h6;
    localparam logic [3:0] ADDR_PROFILE_VEL = 4'h7;
    localparam logic [3:0] ADDR_END_VEL     = 4'h8;
    localparam logic [3:0] ADDR_ACCEL       = 4'h9;
    localparam logic [3:0] ADDR_DECEL       = 4'ha;
    localparam logic [3:0] ADDR_HOME_METHOD = 4'hb;
    localparam logic [3:0] ADDR_ALARM_CODES = 4'hc;
    localparam logic [3:0] ADDR_STATUS      = 4'hd;
    // Control word bit positions
    localparam int CW_RAMP_RUN    = 5;
    localparam int CW_ACTIVATE    = 6;
    localparam int CW_SETPOINT_EN = 6;
    localparam int CW_MASTER_CTRL = 10;
    localparam int CW_HOME        = 11;
    localparam int CW_RELATIVE    = 12;
    localparam int CW_IMMEDIATE   = 13;
    // Telegram numbers, 0 and 1 bound to a mode, 2 free
    localparam logic [1:0] TEL_POS   = 2'h0;
    localparam logic [1:0] TEL_SPEED = 2'h1;
    localparam logic [1:0] TEL_FREE  = 2'h2;
    // Alarm code vendor window
    localparam logic [15:0] VENDOR_BASE     = 16'h1000;
    localparam logic [15:0] VENDOR_MAIN_MAX = 16'h7fff;
    localparam logic [15:0] VENDOR_SUB_MAX  = 16'h100f;
    // Reset values and the rejected mode code
    localparam logic [15:0] RST_RATE        = 16'h0010;
    localparam logic [1:0]  MODE_INVALID    = 2'h3;

    typedef enum logic [1:0] {
        DMC_MODE_POS    = 2'h0,
        DMC_MODE_SPEED  = 2'h1,
        DMC_MODE_TORQUE = 2'h2
    } dmc_mode_t;

    typedef enum logic [1:0] {
        DMC_ST_IDLE  = 2'b00,
        DMC_ST_MOVE  = 2'b01,
        DMC_ST_QUEUE = 2'b11,
        DMC_ST_HOME  = 2'b10
    } dmc_state_t;

    function automatic logic [15:0] dmc_vendor_code(input logic [7:0] idx);
        dmc_vendor_code = VENDOR_BASE + {8'h00, idx};
    endfunction : dmc_vendor_code
endpackage : dmc_pkg

// File: logic/dmc_if.sv
// Carriers between the command core and its ramp and alarm helpers
`timescale 1ns/100ps
interface dmc_ramp_if #(parameter int WIDTH = 16);
    logic signed [WIDTH-1:0] target;
    logic        [WIDTH-1:0] rate;
    logic                    freeze;
    logic signed [WIDTH-1:0] value;
    modport ctl  (output target, output rate, output freeze, input value);
    modport ramp (input target, input rate, input freeze, output value);
endinterface : dmc_ramp_if

interface dmc_alarm_if;
    logic        fault_valid;
    logic [7:0]  fault_main;
    logic [3:0]  fault_sub;
    logic        alarm_valid;
    logic [15:0] main_code;
    logic [15:0] sub_code;
    modport ctl (output fault_valid, output fault_main, output fault_sub,
                 input alarm_valid, input main_code, input sub_code);
    modport enc (input fault_valid, input fault_main, input fault_sub,
                 output alarm_valid, output main_code, output sub_code);
endinterface : dmc_alarm_if

// File: logic/dmc_ramp.sv
// Rate-limited setpoint ramp with freeze
`timescale 1ns/100ps
module dmc_ramp
    import dmc_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic   clk_sys,
    input  wire logic   reset,
    dmc_ramp_if.ramp    rp
);
    if (WIDTH < 2) begin : g_bad_width
        $error("dmc_ramp WIDTH must be at least 2");
    end

    typedef struct packed {
        logic signed [WIDTH-1:0] value;
    } dmc_ramp_state_t;

    dmc_ramp_state_t r_reg;
    dmc_ramp_state_t r_next;
    logic signed [WIDTH+1:0] delta;

    function automatic logic signed [WIDTH-1:0] step(
        input logic signed [WIDTH-1:0] cur,
        input logic signed [WIDTH-1:0] tgt,
        input logic        [WIDTH-1:0] rate);
        logic signed [WIDTH+1:0] diff;
        logic signed [WIDTH+1:0] lim;
        diff = (WIDTH+2)'(tgt) - (WIDTH+2)'(cur);
        lim  = $signed({2'b00, rate});
        // Result lies between cur and tgt, so it cannot overflow
        if (diff > lim)
            step = WIDTH'((WIDTH+2)'(cur) + lim);
        else if (diff < -lim)
            step = WIDTH'((WIDTH+2)'(cur) - lim);
        else
            step = tgt;
    endfunction : step

    always_comb
    begin
        r_next = r_reg;
        if (!rp.freeze)
            r_next.value = step(r_reg.value, rp.target, rp.rate);
        delta = (WIDTH+2)'(r_next.value) - (WIDTH+2)'(r_reg.value);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign rp.value = r_reg.value;

    a_ramp_frozen: assert property (@(posedge clk_sys) disable iff (reset)
        rp.freeze |=> rp.value == $past(rp.value))
        else $error("ramp moved while frozen");
    a_ramp_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (delta <= $signed({2'b00, rp.rate})) &&
        (delta >= -$signed({2'b00, rp.rate})))
        else $error("ramp step exceeds rate");
endmodule : dmc_ramp

// File: logic/dmc_alarm.sv
// Fault number to diagnosis alarm code encoder
`timescale 1ns/100ps
module dmc_alarm
    import dmc_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   reset,
    dmc_alarm_if.enc    al
);
    typedef struct packed {
        logic        valid;
        logic [15:0] main_code;
        logic [15:0] sub_code;
    } dmc_alarm_state_t;

    dmc_alarm_state_t r_reg;
    dmc_alarm_state_t r_next;

    always_comb
    begin
        r_next       = r_reg;
        r_next.valid = 1'b0;
        if (al.fault_valid)
        begin
            r_next.valid     = 1'b1;
            r_next.main_code = dmc_vendor_code(al.fault_main);
            r_next.sub_code  = dmc_vendor_code({4'h0, al.fault_sub});
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign al.alarm_valid = r_reg.valid;
    assign al.main_code   = r_reg.main_code;
    assign al.sub_code    = r_reg.sub_code;

    a_alarm_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        al.fault_valid |=> al.alarm_valid)
        else $error("fault gave no alarm");
    a_alarm_main: assert property (@(posedge clk_sys) disable iff (reset)
        al.alarm_valid |-> al.main_code == VENDOR_BASE
            + {8'h00, $past(al.fault_main)} && al.main_code <= VENDOR_MAIN_MAX)
        else $error("main alarm code wrong");
    a_alarm_sub: assert property (@(posedge clk_sys) disable iff (reset)
        al.alarm_valid |-> al.sub_code == VENDOR_BASE
            + {12'h000, $past(al.fault_sub)} && al.sub_code <= VENDOR_SUB_MAX)
        else $error("sub alarm code wrong");
endmodule : dmc_alarm

// File: logic/dmc_core.sv
// Drive mode selection, setpoint ramps and positioning task control
//
// Summary of operation
// - A drive fault sends a diagnosis alarm to the master.
// - Alarm main code is fault main index plus 1000h.
// - Alarm sub code is fault subindex plus 1000h.
// - Telegram 0 means positioning, telegram 1 means speed control.
// - A new receive telegram number 0 or 1 switches the mode by itself.
// - Torque setpoint passes a rate-limiting ramp in torque mode.
// - Speed setpoint passes an acceleration ramp that can be frozen.
// - Speed mode with fieldbus active selects fixed setpoint 1.
// - Setpoint-enable bit low feeds no setpoint into the adder.
// - A positioning task starts only on a rising control bit 6.
// - Control bit 12 picks relative or absolute target.
// - Control bit 13 aborts the running task or queues the new one.
// - Each move uses profile, end velocity, acceleration, deceleration.
// - End velocity equal profile velocity chains moves without stop.
// - Homing runs in positioning mode with the configured method.
// - Telegram layouts on both sides must match exactly.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
module dmc_core
    import dmc_pkg::*;
#(
    parameter int TARGET_W = 32
)(
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output      logic [31:0]         reg_rdata,
    input  wire logic                rx_valid,
    input  wire logic [1:0]          rx_telegram,
    input  wire logic [15:0]         rx_control_word,
    input  wire logic                fieldbus_active,
    input  wire logic                fault_valid,
    input  wire logic [7:0]          fault_main,
    input  wire logic [3:0]          fault_sub,
    input  wire logic                move_done,
    input  wire logic                home_done,
    output      logic [1:0]          active_mode,
    output      logic [SET_W-1:0]    torque_cmd,
    output      logic [SET_W-1:0]    speed_cmd,
    output      logic                adder_fixed1_sel,
    output      logic                move_start,
    output      logic [TARGET_W-1:0] move_target,
    output      logic                move_relative,
    output      logic [SET_W-1:0]    move_profile_vel,
    output      logic [SET_W-1:0]    move_end_vel,
    output      logic [SET_W-1:0]    move_accel,
    output      logic [SET_W-1:0]    move_decel,
    output      logic                move_blend,
    output      logic                home_start,
    output      logic [7:0]          home_method,
    output      logic                alarm_valid,
    output      logic [15:0]         alarm_main_code,
    output      logic [15:0]         alarm_sub_code
);
    if (TARGET_W < 1 || TARGET_W > 32) begin : g_bad_target
        $error("dmc_core TARGET_W must be 1 to 32");
    end

    typedef struct packed {
        dmc_mode_t           mode;
        dmc_state_t          fsm;
        logic [1:0]          tel;
        logic [15:0]         cw;
        logic [1:0]          mode_param;
        logic [SET_W-1:0]    torque_set;
        logic [SET_W-1:0]    torque_rate;
        logic [SET_W-1:0]    speed_set;
        logic [SET_W-1:0]    speed_rate;
        logic [TARGET_W-1:0] target;
        logic [SET_W-1:0]    prof_vel;
        logic [SET_W-1:0]    end_vel;
        logic [SET_W-1:0]    accel;
        logic [SET_W-1:0]    decel;
        logic [7:0]          home_method;
        logic [TARGET_W-1:0] pend_target;
        logic                pend_rel;
        logic                pend_blend;
        logic [31:0]         rdata;
        logic                mv_start;
        logic [TARGET_W-1:0] mv_target;
        logic                mv_rel;
        logic [SET_W-1:0]    mv_prof;
        logic [SET_W-1:0]    mv_end;
        logic [SET_W-1:0]    mv_acc;
        logic [SET_W-1:0]    mv_dec;
        logic                mv_blend;
        logic                home_start;
    } dmc_core_t;

    localparam dmc_core_t CORE_RST = '{
        mode:        DMC_MODE_POS,
        fsm:         DMC_ST_IDLE,
        torque_rate: RST_RATE,
        speed_rate:  RST_RATE,
        default:     '0
    };

    dmc_core_t r_reg;
    dmc_core_t r_next;
    logic      take;
    logic      pos_mode;
    logic      start_edge;
    logic      home_edge;
    logic      immediate;

    dmc_ramp_if #(.WIDTH(SET_W)) trq_if ();
    dmc_ramp_if #(.WIDTH(SET_W)) spd_if ();
    dmc_alarm_if                 alm_if ();

    // Copies the move profile into the outputs and fires the start pulse
    function automatic dmc_core_t issue(
        input dmc_core_t           s,
        input logic [TARGET_W-1:0] tgt,
        input logic                rel,
        input logic                blend);
        dmc_core_t t;
        t           = s;
        t.mv_start  = 1'b1;
        t.mv_target = tgt;
        t.mv_rel    = rel;
        t.mv_prof   = s.prof_vel;
        t.mv_end    = s.end_vel;
        t.mv_acc    = s.accel;
        t.mv_dec    = s.decel;
        t.mv_blend  = blend;
        issue       = t;
    endfunction : issue

    // commands taken only with master control bit
    assign take       = rx_valid & rx_control_word[CW_MASTER_CTRL];
    assign pos_mode   = (r_reg.mode == DMC_MODE_POS) & (rx_telegram != TEL_SPEED);
    assign start_edge = take & pos_mode & rx_control_word[CW_ACTIVATE]
                        & ~r_reg.cw[CW_ACTIVATE];
    assign home_edge  = take & pos_mode & rx_control_word[CW_HOME]
                        & ~r_reg.cw[CW_HOME];
    assign immediate  = rx_control_word[CW_IMMEDIATE];

    always_comb
    begin
        r_next            = r_reg;
        r_next.mv_start   = 1'b0;
        r_next.home_start = 1'b0;
        r_next.rdata      = '0;

        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_MODE_PARAM:  r_next.mode_param  = reg_wdata[1:0];
                ADDR_TORQUE_SET:  r_next.torque_set  = reg_wdata[SET_W-1:0];
                ADDR_TORQUE_RATE: r_next.torque_rate = reg_wdata[SET_W-1:0];
                ADDR_SPEED_SET:   r_next.speed_set   = reg_wdata[SET_W-1:0];
                ADDR_SPEED_RATE:  r_next.speed_rate  = reg_wdata[SET_W-1:0];
                ADDR_TARGET:      r_next.target = reg_wdata[TARGET_W-1:0];
                ADDR_PROFILE_VEL: r_next.prof_vel    = reg_wdata[SET_W-1:0];
                ADDR_END_VEL:     r_next.end_vel     = reg_wdata[SET_W-1:0];
                ADDR_ACCEL:       r_next.accel       = reg_wdata[SET_W-1:0];
                ADDR_DECEL:       r_next.decel       = reg_wdata[SET_W-1:0];
                ADDR_HOME_METHOD: r_next.home_method = reg_wdata[7:0];
                default:          r_next.rdata       = '0;
            endcase
        end

        // explicit mode only for free telegrams
        if (reg_wr && reg_addr == ADDR_MODE_PARAM && r_reg.tel >= TEL_FREE
            && reg_wdata[1:0] != MODE_INVALID)
            r_next.mode = dmc_mode_t'(reg_wdata[1:0]);

        if (rx_valid)
        begin
            r_next.tel = rx_telegram;
            r_next.cw  = rx_control_word;
            if (rx_telegram == TEL_POS)
                r_next.mode = DMC_MODE_POS;
            else if (rx_telegram == TEL_SPEED)
                r_next.mode = DMC_MODE_SPEED;
        end

        // bits 12 and 13 taken with the edge
        case (r_reg.fsm)
            DMC_ST_IDLE:
            begin
                if (start_edge)
                begin
                    r_next     = issue(r_next, r_reg.target,
                                       rx_control_word[CW_RELATIVE], 1'b0);
                    r_next.fsm = DMC_ST_MOVE;
                end
                else if (home_edge)
                begin
                    r_next.home_start = 1'b1;
                    r_next.fsm        = DMC_ST_HOME;
                end
            end
            DMC_ST_MOVE, DMC_ST_QUEUE:
            begin
                if (start_edge && immediate)
                begin
                    r_next     = issue(r_next, r_reg.target,
                                       rx_control_word[CW_RELATIVE], 1'b0);
                    r_next.fsm = DMC_ST_MOVE;
                end
                else if (start_edge)
                begin
                    r_next.pend_target = r_reg.target;
                    r_next.pend_rel    = rx_control_word[CW_RELATIVE];
                    // chain when end equals profile velocity
                    r_next.pend_blend  = (r_reg.mv_end == r_reg.mv_prof);
                    r_next.fsm         = DMC_ST_QUEUE;
                end
                else if (move_done && r_reg.fsm == DMC_ST_QUEUE)
                begin
                    // profile applied to the queued move
                    r_next     = issue(r_next, r_reg.pend_target,
                                       r_reg.pend_rel, r_reg.pend_blend);
                    r_next.fsm = DMC_ST_MOVE;
                end
                else if (move_done)
                    r_next.fsm = DMC_ST_IDLE;
            end
            DMC_ST_HOME:
            begin
                if (home_done)
                    r_next.fsm = DMC_ST_IDLE;
            end
            default:
                r_next.fsm = DMC_ST_IDLE;
        endcase

        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_MODE_PARAM:  r_next.rdata = {30'h0, r_reg.mode_param};
                ADDR_MODE_ACTIVE: r_next.rdata = {30'h0, r_reg.mode};
                ADDR_TORQUE_SET:  r_next.rdata = 32'(r_reg.torque_set);
                ADDR_TORQUE_RATE: r_next.rdata = 32'(r_reg.torque_rate);
                ADDR_SPEED_SET:   r_next.rdata = 32'(r_reg.speed_set);
                ADDR_SPEED_RATE:  r_next.rdata = 32'(r_reg.speed_rate);
                ADDR_TARGET:      r_next.rdata = 32'(r_reg.target);
                ADDR_PROFILE_VEL: r_next.rdata = 32'(r_reg.prof_vel);
                ADDR_END_VEL:     r_next.rdata = 32'(r_reg.end_vel);
                ADDR_ACCEL:       r_next.rdata = 32'(r_reg.accel);
                ADDR_DECEL:       r_next.rdata = 32'(r_reg.decel);
                ADDR_HOME_METHOD: r_next.rdata = {24'h0, r_reg.home_method};
                ADDR_ALARM_CODES:
                    r_next.rdata = {alm_if.sub_code, alm_if.main_code};
                ADDR_STATUS:
                    r_next.rdata = {28'h0, r_reg.fsm, r_reg.tel};
                default:          r_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            r_reg <= CORE_RST;
        else
            r_reg <= r_next;
    end

    // torque setpoint ramp, zero outside torque mode
    assign trq_if.target = (r_reg.mode == DMC_MODE_TORQUE)
                           ? r_reg.torque_set : '0;
    assign trq_if.rate   = r_reg.torque_rate;
    assign trq_if.freeze = 1'b0;

    // speed ramp, frozen while ramp-run bit is low
    assign spd_if.target = r_reg.speed_set;
    assign spd_if.rate   = r_reg.speed_rate;
    assign spd_if.freeze = ~r_reg.cw[CW_RAMP_RUN];

    dmc_ramp #(.WIDTH(SET_W)) u_trq_ramp (
        .clk_sys (clk_sys),
        .reset   (reset),
        .rp      (trq_if.ramp)
    );

    dmc_ramp #(.WIDTH(SET_W)) u_spd_ramp (
        .clk_sys (clk_sys),
        .reset   (reset),
        .rp      (spd_if.ramp)
    );

    assign alm_if.fault_valid = fault_valid;
    assign alm_if.fault_main  = fault_main;
    assign alm_if.fault_sub   = fault_sub;

    dmc_alarm u_alarm (
        .clk_sys (clk_sys),
        .reset   (reset),
        .al      (alm_if.enc)
    );

    // fixed setpoint 1 on the adder
    assign adder_fixed1_sel = (r_reg.mode == DMC_MODE_SPEED)
                              & fieldbus_active & r_reg.cw[CW_SETPOINT_EN];
    assign speed_cmd        = adder_fixed1_sel ? spd_if.value : '0;
    assign torque_cmd       = trq_if.value;
    assign active_mode      = r_reg.mode;
    assign reg_rdata        = r_reg.rdata;
    assign move_start       = r_reg.mv_start;
    assign move_target      = r_reg.mv_target;
    assign move_relative    = r_reg.mv_rel;
    assign move_profile_vel = r_reg.mv_prof;
    assign move_end_vel     = r_reg.mv_end;
    assign move_accel       = r_reg.mv_acc;
    assign move_decel       = r_reg.mv_dec;
    assign move_blend       = r_reg.mv_blend;
    assign home_start       = r_reg.home_start;
    assign home_method      = r_reg.home_method;
    assign alarm_valid      = alm_if.alarm_valid;
    assign alarm_main_code  = alm_if.main_code;
    assign alarm_sub_code   = alm_if.sub_code;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_tel_mode_bind: assert property (
        rx_valid && rx_telegram == TEL_SPEED |=> active_mode == 2'h1)
        else $error("telegram 1 did not select speed mode");
    a_start_rising: assert property (
        move_start && !$past(r_reg.fsm == DMC_ST_QUEUE && move_done)
            |-> $past(rx_valid && rx_control_word[6] && !r_reg.cw[6]))
        else $error("move started without rising bit 6");
    a_rel_sampled: assert property (
        start_edge && r_reg.fsm == DMC_ST_IDLE
            |=> move_start && move_relative == $past(rx_control_word[12]))
        else $error("relative bit not taken with start edge");
    a_queue_append: assert property (
        start_edge && !immediate && r_reg.fsm == DMC_ST_MOVE
            |=> !move_start && r_reg.fsm == DMC_ST_QUEUE)
        else $error("appended task did not queue");
    a_queue_launch: assert property (
        r_reg.fsm == DMC_ST_QUEUE && move_done && !start_edge
            |=> move_start && move_blend == $past(r_reg.pend_blend))
        else $error("queued task not launched at done");
    a_adder_gate: assert property (
        !r_reg.cw[CW_SETPOINT_EN] |-> !adder_fixed1_sel && speed_cmd == '0)
        else $error("setpoint fed while disabled");
    a_home_pos: assert property (
        home_start |-> $past(active_mode) == 2'h0 && r_reg.fsm == DMC_ST_HOME)
        else $error("homing outside positioning mode");
endmodule : dmc_core

// File: tb/dmc_plc_model.sv
// Cyclic controller model that presents receive telegrams
`timescale 1ns/100ps
module dmc_plc_model (
    input  wire logic        send,
    input  wire logic [1:0]  tel,
    input  wire logic [15:0] cw,
    output      logic        rx_valid,
    output      logic [1:0]  rx_telegram,
    output      logic [15:0] rx_control_word
);
    // matching layout, number beside control word
    assign rx_valid = send;
    // Outside a telegram the fields carry their inverse, never a stale copy
    assign rx_telegram = send ? tel : ~tel;
    assign rx_control_word = send ? (cw | 16'h0400) : ~cw;
endmodule : dmc_plc_model

// File: tb/tb_drive_mode_motion_command.sv
// Self-checking bench for the drive mode and motion command core
`timescale 1ns/100ps
module tb_drive_mode_motion_command
    import dmc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, move_target;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, move_done = 1'b0;
    logic        fault_valid = 1'b0, send = 1'b0, rx_valid, adder_sel;
    logic        move_start, move_rel, move_blend, home_start, alarm_valid;
    logic [7:0]  fault_main = 8'h00, home_method;
    logic [3:0]  fault_sub = 4'h0;
    logic [1:0]  tel = 2'h0, rx_telegram, active_mode;
    logic [15:0] cw = 16'h0000, rx_control_word, am_code, as_code, prof;
    logic [15:0] trq, spd;
    logic [43:0] rows [3] = '{44'h08_6_1008_1006, 44'h00_0_1000_1000,
                              44'hff_f_10ff_100f};
    int          num_errors = 0;
    int          total_checks = 0;

    dmc_plc_model plc (.send(send), .tel(tel), .cw(cw), .rx_valid(rx_valid),
        .rx_telegram(rx_telegram), .rx_control_word(rx_control_word));
    dmc_core uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_telegram(rx_telegram), .rx_control_word(rx_control_word),
        .fieldbus_active(1'b1), .fault_valid(fault_valid),
        .fault_main(fault_main), .fault_sub(fault_sub),
        .move_done(move_done), .home_done(1'b0), .active_mode(active_mode),
        .torque_cmd(trq), .speed_cmd(spd), .adder_fixed1_sel(adder_sel),
        .move_start(move_start), .move_target(move_target),
        .move_relative(move_rel), .move_profile_vel(prof),
        .move_end_vel(), .move_accel(), .move_decel(),
        .move_blend(move_blend), .home_start(home_start),
        .home_method(home_method), .alarm_valid(alarm_valid),
        .alarm_main_code(am_code), .alarm_sub_code(as_code));

    always #20 clk_sys = ~clk_sys;

    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic print_verdict;
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // Every request waits its own edge, so no strobe is set twice at once
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    task automatic tg(input logic [1:0] t, input logic [15:0] c);
        @(posedge clk_sys);
        tel <= t;
        cw <= c;
        send <= 1'b1;
        @(posedge clk_sys);
        send <= 1'b0;
        #1;
    endtask : tg
    task automatic done;
        @(posedge clk_sys);
        move_done <= 1'b1;
        @(posedge clk_sys);
        move_done <= 1'b0;
        #1;
    endtask : done

    initial
    begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        chk("mode after reset", DMC_MODE_POS, active_mode);
        rd(ADDR_TORQUE_RATE);
        chk("rate after reset", RST_RATE, rd_val);
        rd(4'hf);
        chk("unmapped read", 0, rd_val);
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            {fault_main, fault_sub} <= rows[i][43:32];
            fault_valid <= 1'b1;
            @(posedge clk_sys);
            fault_valid <= 1'b0;
            #1;
            chk("alarm valid", 1, alarm_valid);
            chk("main code", rows[i][31:16], am_code);
            chk("sub code", rows[i][15:0], as_code);
        end
        rd(ADDR_ALARM_CODES);
        chk("alarm codes", 32'h100f_10ff, rd_val);
        wr(ADDR_SPEED_SET, 32'h100);
        tg(TEL_SPEED, 16'h0060);
        chk("speed mode", DMC_MODE_SPEED, active_mode);
        chk("fixed setpoint", 1, adder_sel);
        @(posedge clk_sys);
        #1 chk("speed ramp", RST_RATE, spd);
        tg(TEL_SPEED, 16'h0000);
        chk("no setpoint", 0, adder_sel);
        chk("speed gated", 0, spd);
        tg(TEL_FREE, 16'h0000);
        wr(ADDR_MODE_PARAM, 2);
        rd(ADDR_MODE_ACTIVE);
        chk("mode param", DMC_MODE_TORQUE, rd_val);
        wr(ADDR_TORQUE_SET, 32'h100);
        @(posedge clk_sys);
        #1 chk("torque ramp", RST_RATE, trq);
        tg(TEL_POS, 16'h0000);
        chk("pos mode", DMC_MODE_POS, active_mode);
        wr(ADDR_TARGET, 32'h100);
        wr(ADDR_PROFILE_VEL, 5);
        wr(ADDR_END_VEL, 5);
        tg(TEL_POS, 16'h1040);
        chk("start", 1, move_start);
        chk("relative", 1, move_rel);
        chk("target", 32'h100, move_target);
        chk("profile", 5, prof);
        tg(TEL_POS, 16'h1040);
        chk("held bit", 0, move_start);
        tg(TEL_POS, 16'h0000);
        tg(TEL_POS, 16'h2040);
        chk("abort start", 1, move_start);
        tg(TEL_POS, 16'h0000);
        wr(ADDR_TARGET, 32'h200);
        tg(TEL_POS, 16'h0040);
        chk("queued", 0, move_start);
        done();
        chk("queued start", 1, move_start);
        chk("absolute", 0, move_rel);
        chk("queued target", 32'h200, move_target);
        chk("blend", 1, move_blend);
        done();
        tg(TEL_POS, 16'h0000);
        wr(ADDR_HOME_METHOD, 3);
        tg(TEL_POS, 16'h0800);
        chk("home start", 1, home_start);
        chk("home method", 3, home_method);
        print_verdict();
    end
endmodule : tb_drive_mode_motion_command
